// ===== core/lrg_defs.vh
`ifndef LRG_DEFS_VH
`define LRG_DEFS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define LRG_ADDR_W 8
`define LRG_DATA_W 32
`define LRG_CTRL_OFF 8'h00
`define LRG_STAT_OFF 8'h04
`define LRG_MASK_OFF 8'h08
`define LRG_TMR_OFF 8'h0C
`define LRG_CMP_OFF 8'h10

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define LRG_TEST_BIT 9
`define LRG_GATE_BIT 8
`define LRG_MODE_BIT 6

// ----------------------------------------------------------------
// Status and mask field positions
// ----------------------------------------------------------------
`define LRG_ST_BRK_EDGE 0
`define LRG_ST_OVF 1
`define LRG_ST_SYNC 2
`define LRG_ST_CMP 3
`define LRG_ST_BRK 4
`define LRG_ST_W 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LRG_CTRL_RST 1'b0
`define LRG_MASK_RST 5'h00
`define LRG_CMP_RST 16'hFFFF
`define LRG_BUS_IDLE 1'b1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LRG_TMR_W 16
`define LRG_CLK_MHZ 40
`define LRG_BRK_MIN_NS 5000
`define LRG_BRK_MIN_CYC ((`LRG_BRK_MIN_NS * `LRG_CLK_MHZ + 999) / 1000)
`define LRG_BRK_CNT_W 16
`define LRG_SYNC_RISES 5

`endif

// ===== core/lrg_edge_det.v
`timescale 1ns/100ps
module lrg_edge_det
(
    // Clock and reset
    input wire clk,
    input wire srst,
    // Bus level
    input wire d,
    output wire lvl,
    output wire rise,
    output wire fall
);

// ----------------------------------------------------------------
// Two stage history, idles high like the released bus
// ----------------------------------------------------------------
reg d1_q;
reg d2_q;

always @(posedge clk)
begin
    if (srst)
    begin
        d1_q <= 1'b1;
        d2_q <= 1'b1;
    end
    else
    begin
        d1_q <= d;
        d2_q <= d1_q;
    end
end

assign lvl = d1_q;
assign rise = d1_q & ~d2_q;
assign fall = ~d1_q & d2_q;

endmodule

// ===== core/lrg_pw_timer.v
`timescale 1ns/100ps
module lrg_pw_timer
#(
    parameter W = 16
)
(
    // Clock and reset
    input wire clk,
    input wire srst,
    // Edge controls
    input wire start,
    input wire stop,
    // Compare value
    input wire [W-1:0] cmp,
    // Results
    output reg [W-1:0] cnt_q,
    output reg run_q,
    output reg match_q,
    output reg ovf_q
);

wire [W-1:0] all_ones;

assign all_ones = {W{1'b1}};

// ----------------------------------------------------------------
// Width counter
// ----------------------------------------------------------------
always @(posedge clk)
begin
    if (srst)
    begin
        cnt_q <= {W{1'b0}};
        run_q <= 1'b0;
        match_q <= 1'b0;
        ovf_q <= 1'b0;
    end
    else
    begin
        match_q <= run_q & ~stop & ~start & (cnt_q == cmp);
        ovf_q <= run_q & ~stop & ~start & (cnt_q == all_ones);
        if (start)
        begin
            cnt_q <= {W{1'b0}};
            run_q <= 1'b1;
        end
        else if (stop)
        begin
            // Count is held so software can read back the width
            run_q <= 1'b0;
        end
        else if (run_q)
        begin
            cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule

// ===== core/lrg_top.v
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/100ps
`include "lrg_defs.vh"
module lrg_top
#(
    parameter TMR_W = `LRG_TMR_W,
    parameter BRK_MIN_CYC = `LRG_BRK_MIN_CYC,
    parameter SYNC_RISES = `LRG_SYNC_RISES
)
(
    // Clock and reset
    input wire clk,
    input wire srst,
    // Register port
    input wire [`LRG_ADDR_W-1:0] reg_addr,
    input wire [`LRG_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`LRG_DATA_W-1:0] reg_rdata_q,
    // Interrupt
    output reg irq_q,
    // Transceiver side
    input wire lin_rx_i,
    output reg lin_tx_q,
    // UART side
    input wire uart_tx_i,
    output reg uart_rx_q,
    // Test pins
    input wire tp_tx_i,
    output reg tp_rx_q,
    // Frame state
    output reg frame_sync_q
);

// ----------------------------------------------------------------
// Local constants
// ----------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'b00;
localparam [1:0] ST_BREAK = 2'b01;
localparam [1:0] ST_SYNC = 2'b10;
localparam [1:0] ST_DONE = 2'b11;
localparam integer BRK_LIM_I = BRK_MIN_CYC;
localparam integer SYNC_LAST_I = SYNC_RISES - 1;
localparam [`LRG_BRK_CNT_W-1:0] BRK_LIM = BRK_LIM_I[`LRG_BRK_CNT_W-1:0];
localparam [2:0] SYNC_LAST = SYNC_LAST_I[2:0];

// ----------------------------------------------------------------
// Declarations
// ----------------------------------------------------------------
reg test_q;
reg gate_q;
reg mode_q;
reg [`LRG_ST_W-1:0] stat_q;
reg [`LRG_ST_W-1:0] stat_d;
reg [`LRG_ST_W-1:0] mask_q;
reg [TMR_W-1:0] cmp_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg [`LRG_BRK_CNT_W-1:0] low_cnt_q;
reg [2:0] rise_cnt_q;
reg [2:0] rise_cnt_d;
reg sync_done_d;
reg [`LRG_DATA_W-1:0] rdata_d;
reg brk_ev;
reg sync_ev;
wire bus_lvl;
wire bus_rise;
wire bus_fall;
wire [TMR_W-1:0] tmr_cnt;
wire tmr_match;
wire tmr_ovf;
wire wr_ctrl;
wire wr_mask;
wire wr_cmp;
wire rd_stat;
wire brk_edge_ev;
wire long_low;
wire [`LRG_ST_W-1:0] stat_set;

// ----------------------------------------------------------------
// Bus edge detection
// ----------------------------------------------------------------
lrg_edge_det u_edge
(
    .clk (clk),
    .srst (srst),
    .d (lin_rx_i),
    .lvl (bus_lvl),
    .rise (bus_rise),
    .fall (bus_fall)
);

// ----------------------------------------------------------------
// Pulse width timer
// ----------------------------------------------------------------
// Runs in both modes: low phase measurement in read and write alike
lrg_pw_timer
#(
    .W (TMR_W)
)
u_tmr
(
    .clk (clk),
    .srst (srst),
    .start (bus_fall),
    .stop (bus_rise),
    .cmp (cmp_q),
    .cnt_q (tmr_cnt),
    .run_q (),
    .match_q (tmr_match),
    .ovf_q (tmr_ovf)
);

// ----------------------------------------------------------------
// Register decode
// ----------------------------------------------------------------
assign wr_ctrl = reg_wr & (reg_addr == `LRG_CTRL_OFF);
assign wr_mask = reg_wr & (reg_addr == `LRG_MASK_OFF);
assign wr_cmp = reg_wr & (reg_addr == `LRG_TMR_OFF);
assign rd_stat = reg_rd & (reg_addr == `LRG_STAT_OFF);

always @(posedge clk)
begin
    if (srst)
    begin
        test_q <= `LRG_CTRL_RST;
        gate_q <= `LRG_CTRL_RST;
        mode_q <= `LRG_CTRL_RST;
        mask_q <= `LRG_MASK_RST;
        cmp_q <= `LRG_CMP_RST;
    end
    else
    begin
        if (wr_ctrl)
        begin
            test_q <= reg_wdata[`LRG_TEST_BIT];
            gate_q <= reg_wdata[`LRG_GATE_BIT];
            mode_q <= reg_wdata[`LRG_MODE_BIT];
        end
        if (wr_mask)
        begin
            mask_q <= reg_wdata[`LRG_ST_W-1:0];
        end
        if (wr_cmp)
        begin
            cmp_q <= reg_wdata[TMR_W-1:0];
        end
    end
end

// ----------------------------------------------------------------
// Break and sync measurement
// ----------------------------------------------------------------
// A low run of at least the break length starts a frame; the sync
// byte ends on its last rising edge, with the stop bit high after it
assign long_low = (low_cnt_q == BRK_LIM);

always @(posedge clk)
begin
    if (srst)
    begin
        low_cnt_q <= {`LRG_BRK_CNT_W{1'b0}};
    end
    else if (bus_lvl | mode_q)
    begin
        low_cnt_q <= {`LRG_BRK_CNT_W{1'b0}};
    end
    else if (!long_low)
    begin
        low_cnt_q <= low_cnt_q + {{(`LRG_BRK_CNT_W-1){1'b0}}, 1'b1};
    end
end

always @*
begin
    state_d = state_q;
    rise_cnt_d = rise_cnt_q;
    sync_done_d = frame_sync_q;
    brk_ev = 1'b0;
    sync_ev = 1'b0;
    if (mode_q)
    begin
        state_d = ST_IDLE;
        rise_cnt_d = 3'h0;
        sync_done_d = 1'b0;
    end
    else
    begin
        case (state_q)
            ST_IDLE, ST_DONE:
            begin
                if (long_low)
                begin
                    state_d = ST_BREAK;
                    sync_done_d = 1'b0;
                    brk_ev = 1'b1;
                end
            end
            ST_BREAK:
            begin
                rise_cnt_d = 3'h0;
                if (bus_rise)
                begin
                    state_d = ST_SYNC;
                end
            end
            ST_SYNC:
            begin
                if (long_low)
                begin
                    // Another break restarts the frame
                    state_d = ST_BREAK;
                    brk_ev = 1'b1;
                end
                else if (bus_rise)
                begin
                    rise_cnt_d = rise_cnt_q + 3'h1;
                    if (rise_cnt_q == SYNC_LAST)
                    begin
                        state_d = ST_DONE;
                        sync_done_d = 1'b1;
                        sync_ev = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end
end

always @(posedge clk)
begin
    if (srst)
    begin
        state_q <= ST_IDLE;
        rise_cnt_q <= 3'h0;
        frame_sync_q <= 1'b0;
    end
    else
    begin
        state_q <= state_d;
        rise_cnt_q <= rise_cnt_d;
        frame_sync_q <= sync_done_d;
    end
end

// ----------------------------------------------------------------
// Status, mask and interrupt
// ----------------------------------------------------------------
// Gate clear in serial bus mode keeps bus release from raising edge events
assign brk_edge_ev = mode_q & gate_q & bus_rise;

assign stat_set[`LRG_ST_BRK_EDGE] = brk_edge_ev;
assign stat_set[`LRG_ST_OVF] = tmr_ovf;
assign stat_set[`LRG_ST_SYNC] = sync_ev;
assign stat_set[`LRG_ST_CMP] = tmr_match;
assign stat_set[`LRG_ST_BRK] = brk_ev;

always @*
begin
    stat_d = stat_q;
    if (rd_stat)
    begin
        stat_d = {`LRG_ST_W{1'b0}};
    end
    // Set wins over the read clear so no event is lost
    stat_d = stat_d | stat_set;
end

always @(posedge clk)
begin
    if (srst)
    begin
        stat_q <= {`LRG_ST_W{1'b0}};
        irq_q <= 1'b0;
    end
    else
    begin
        stat_q <= stat_d;
        irq_q <= |(stat_d & mask_q);
    end
end

// ----------------------------------------------------------------
// Read data
// ----------------------------------------------------------------
always @*
begin
    rdata_d = {`LRG_DATA_W{1'b0}};
    case (reg_addr)
        `LRG_CTRL_OFF:
        begin
            rdata_d[`LRG_TEST_BIT] = test_q;
            rdata_d[`LRG_GATE_BIT] = gate_q;
            rdata_d[`LRG_MODE_BIT] = mode_q;
        end
        `LRG_STAT_OFF:
        begin
            rdata_d[`LRG_ST_W-1:0] = stat_q;
        end
        `LRG_MASK_OFF:
        begin
            rdata_d[`LRG_ST_W-1:0] = mask_q;
        end
        `LRG_TMR_OFF:
        begin
            rdata_d[TMR_W-1:0] = tmr_cnt;
        end
        `LRG_CMP_OFF:
        begin
            rdata_d[TMR_W-1:0] = cmp_q;
        end
        default:
        begin
            rdata_d = {`LRG_DATA_W{1'b0}};
        end
    endcase
end

always @(posedge clk)
begin
    if (srst)
    begin
        reg_rdata_q <= {`LRG_DATA_W{1'b0}};
    end
    else if (reg_rd)
    begin
        reg_rdata_q <= rdata_d;
    end
    else
    begin
        reg_rdata_q <= {`LRG_DATA_W{1'b0}};
    end
end

// ----------------------------------------------------------------
// Pin routing
// ----------------------------------------------------------------
// Paths are registered, so each adds one cycle of delay; the
// test pin functions must already be selected in port config
always @(posedge clk)
begin
    if (srst)
    begin
        lin_tx_q <= `LRG_BUS_IDLE;
        uart_rx_q <= `LRG_BUS_IDLE;
        tp_rx_q <= `LRG_BUS_IDLE;
    end
    else if (test_q)
    begin
        lin_tx_q <= tp_tx_i;
        tp_rx_q <= lin_rx_i;
        uart_rx_q <= `LRG_BUS_IDLE;
    end
    else
    begin
        lin_tx_q <= uart_tx_i;
        tp_rx_q <= `LRG_BUS_IDLE;
        if (!mode_q && gate_q && !sync_done_d)
        begin
            uart_rx_q <= `LRG_BUS_IDLE;
        end
        else
        begin
            uart_rx_q <= lin_rx_i;
        end
    end
end

endmodule

// ===== sim/lrg_bus_node.sv
`timescale 1ns/100ps
module lrg_bus_node
(
    // Clock
    input wire logic clk,
    // Bus
    input wire logic lin_tx,
    output logic lin_rx
);
    logic drv_q = 1'b1;
    // Dominant low wins, so node and transceiver share the line
    assign lin_rx = drv_q & lin_tx;
    task automatic set(input logic v);
        @(posedge clk);
        drv_q <= v;
    endtask
    task automatic pulse(input int lo, input int hi);
        set(1'b0);
        repeat (lo) @(posedge clk);
        drv_q <= 1'b1;
        repeat (hi) @(posedge clk);
    endtask
endmodule

// ===== sim/lrg_checker_assertions.sv
`timescale 1ns/100ps
module lrg_checker
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic irq_q,
    // Pins
    input wire logic lin_rx_i,
    input wire logic lin_tx_q,
    input wire logic uart_tx_i,
    input wire logic uart_rx_q,
    input wire logic tp_tx_i,
    input wire logic tp_rx_q,
    input wire logic frame_sync_q
);
    // Shadows of control and mask, since only the ports are visible
    logic [31:0] ctl_q;
    logic [31:0] mk_q;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctl_q <= 32'h0;
            mk_q <= 32'h0;
        end
        else if (reg_wr && reg_addr == 8'h00)
            ctl_q <= reg_wdata;
        else if (reg_wr && reg_addr == 8'h08)
            mk_q <= reg_wdata;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_gated;
        $past(ctl_q[8]) && !$past(ctl_q[6]) && !$past(ctl_q[9]);
    endsequence
    sequence s_unmapped_rd;
        reg_rd && reg_addr == 8'h14;
    endsequence
    AST_TEST_TX: assert property ($past(ctl_q[9]) |-> lin_tx_q == $past(tp_tx_i))
        else $error("test path transmit wrong");
    AST_TEST_RX: assert property ($past(ctl_q[9]) |-> tp_rx_q == $past(lin_rx_i))
        else $error("test path receive wrong");
    AST_TEST_URX: assert property ($past(ctl_q[9]) |-> uart_rx_q)
        else $error("uart receive not idle in test path");
    AST_NORM_TX: assert property (!$past(ctl_q[9]) |-> lin_tx_q == $past(uart_tx_i))
        else $error("uart transmit not routed");
    AST_NORM_TP: assert property (!$past(ctl_q[9]) |-> tp_rx_q)
        else $error("test pin driven in normal path");
    AST_GATE_HOLD: assert property (s_gated ##0 !frame_sync_q |-> uart_rx_q)
        else $error("uart receive not gated");
    AST_FS_IDLE: assert property ($past(ctl_q[6], 2) && $past(ctl_q[6]) |-> !frame_sync_q)
        else $error("frame sync in serial bus mode");
    AST_IRQ_MASK: assert property ($past(mk_q[4:0]) == 5'h00 && mk_q[4:0] == 5'h00 |-> !irq_q)
        else $error("interrupt with mask clear");
    AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data outside read cycle");
    AST_UNMAP: assert property (s_unmapped_rd |=> reg_rdata_q == 32'h0)
        else $error("unmapped read not zero");
endmodule
bind lrg_top lrg_checker i_chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .irq_q,
    .lin_rx_i, .lin_tx_q, .uart_tx_i, .uart_rx_q, .tp_tx_i, .tp_rx_q, .frame_sync_q);

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic uart_tx_i = 1'b1;
    logic tp_tx_i = 1'b1;
    wire [31:0] reg_rdata_q;
    wire irq_q, lin_rx, lin_tx_q, uart_rx_q, tp_rx_q, frame_sync_q;
    int err_total = 0;
    int checks_done = 0;
    logic [31:0] v, w;
    always #12.5 clk = ~clk;
    // Short break threshold keeps the run brief
    lrg_top #(.BRK_MIN_CYC(8)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q), .lin_rx_i(lin_rx),
        .lin_tx_q(lin_tx_q), .uart_tx_i(uart_tx_i), .uart_rx_q(uart_rx_q), .tp_tx_i(tp_tx_i),
        .tp_rx_q(tp_rx_q), .frame_sync_q(frame_sync_q));
    lrg_bus_node i_node (.clk(clk), .lin_tx(lin_tx_q), .lin_rx(lin_rx));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_q;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(8'h00, v); chk("ctrl", 32'h0, v);
        rd(8'h08, v); chk("mask", 32'h0, v);
        rd(8'h10, v); chk("cmp", 32'hFFFF, v);
        wr(8'h04, 32'h1F);
        rd(8'h04, v); chk("status", 32'h0, v);
        wr(8'h14, 32'hFFFFFFFF);
        rd(8'h14, v); chk("unmapped", 32'h0, v);
        $display("t_regs done");
    endtask
    task automatic t_test_path;
        wr(8'h00, 32'h200); // test pin functions are taken as already selected
        @(posedge clk) tp_tx_i <= 1'b0;
        cyc(3);
        chk("lin_tx", 32'h0, 32'(lin_tx_q));
        chk("tp_rx", 32'h0, 32'(tp_rx_q));
        chk("uart_rx", 32'h1, 32'(uart_rx_q));
        tp_tx_i <= 1'b1;
        wr(8'h00, 32'h0);
        @(posedge clk) uart_tx_i <= 1'b0;
        cyc(3);
        chk("lin_tx", 32'h0, 32'(lin_tx_q));
        chk("tp_rx", 32'h1, 32'(tp_rx_q));
        uart_tx_i <= 1'b1;
        cyc(3);
        $display("t_test_path done");
    endtask
    task automatic t_gate;
        wr(8'h00, 32'h100);
        rd(8'h04, v);
        i_node.pulse(12, 4);
        repeat (5) i_node.pulse(3, 3);
        chk("sync", 32'h1, 32'(frame_sync_q));
        rd(8'h04, v); chk("brk sync", 32'h14, v & 32'h14);
        i_node.set(1'b0); cyc(3);
        chk("uart pass", 32'h0, 32'(uart_rx_q));
        i_node.set(1'b1);
        i_node.pulse(12, 3);
        chk("sync clr", 32'h0, 32'(frame_sync_q));
        i_node.set(1'b0);
        cyc(3);
        chk("gated", 32'h1, 32'(uart_rx_q));
        i_node.set(1'b1);
        cyc(3);
        wr(8'h00, 32'h0);
        i_node.set(1'b0); cyc(3);
        chk("ungated", 32'h0, 32'(uart_rx_q));
        i_node.set(1'b1); cyc(3);
        $display("t_gate done");
    endtask
    task automatic t_bsd_read;
        wr(8'h00, 32'h140);
        wr(8'h0C, 32'h5);
        wr(8'h08, 32'h09);
        rd(8'h04, v);
        i_node.pulse(10, 4);
        chk("irq", 32'h1, 32'(irq_q));
        rd(8'h04, v); chk("events", 32'h09, v & 32'h0F);
        rd(8'h0C, v); cyc(4); rd(8'h0C, w);
        chk("width", 32'h1, 32'(v >= 8 && v <= 12 && v == w));
        rd(8'h04, v); chk("cleared", 32'h0, v & 32'h09);
        chk("irq off", 32'h0, 32'(irq_q));
        $display("t_bsd_read done");
    endtask
    task automatic t_bsd_write;
        int n;
        wr(8'h00, 32'h040);
        wr(8'h0C, 32'h6);
        rd(8'h04, v);
        @(posedge clk) uart_tx_i <= 1'b0;
        n = 0;
        do rd(8'h04, v); while (!v[3] && ++n < 50);
        if (n >= 50)
        begin
            err_total++;
            $display("BAD compare match wait exp 1 got 0");
            wrap_up();
        end
        @(posedge clk) uart_tx_i <= 1'b1;
        cyc(4);
        rd(8'h04, v); chk("no edge", 32'h0, v & 32'h1);
        rd(8'h0C, v); cyc(5); rd(8'h0C, w);
        chk("held", 32'h1, 32'(v >= 6 && v == w));
        $display("t_bsd_write done");
    endtask
    task automatic t_ovf;
        wr(8'h00, 32'h140);
        wr(8'h08, 32'h0);
        rd(8'h04, v);
        i_node.pulse(65545, 4);
        chk("masked", 32'h0, 32'(irq_q));
        rd(8'h04, v); chk("ovf", 32'h2, v & 32'h2);
        $display("t_ovf done");
    endtask
    initial
    begin
        cyc(10);
        srst <= 1'b0;
        t_regs();
        t_test_path();
        t_gate();
        t_bsd_read();
        t_bsd_write();
        t_ovf();
        wrap_up();
    end
endmodule
